// *** core/mcas_defines.svh ***
// Functional notes
// RULE1: Output word is sixteen points: twelve data bits plus four channel bits.
// RULE2: Channel count is one plus the installed jumper weights 8, 4, 2, 1.
// RULE3: Channels past the selected count are never converted nor reported.
// RULE4: Each channel gets a two millisecond conversion slot before moving on.
// RULE5: Results are twelve-bit unsigned, 4096 steps, one count per LSB.
// RULE6: Two range selects: one for channels 1-8, one for channels 9-16.
// RULE7: The two bank range selects act independently of each other.
// RULE8: Default is zero-based range on both banks and all sixteen channels.
// RULE9: Controller may pull up to sixteen readings in one scan by sampling repeatedly.
// RULE10: Word advances one channel per controller read, ascending order.
// RULE11: After the last enabled channel the sequence wraps to channel one.
// RULE12: Channel field holds channel number minus one, 0000 to 1111.
// RULE13: Data bits hold straight binary, zero to 4095 at full scale.
`ifndef MCAS_DEFINES_SVH
`define MCAS_DEFINES_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define MCAS_CLK_MHZ 125
`define MCAS_CONV_TIME_US 2000
`define MCAS_CONV_CYCLES (`MCAS_CONV_TIME_US * `MCAS_CLK_MHZ)
`define MCAS_TMR_W 18
`define MCAS_SYNC_CYCLES 2'h2
// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define MCAS_JMP_RESET 4'hF
`define MCAS_RANGE_RESET 1'h0
`define MCAS_CHAN_FIRST 4'h0
`define MCAS_BANK_BIT 3
`define MCAS_FIFO_DEPTH 16
`define MCAS_WORD_W 16
`endif

// *** core/mcas_pkg.sv ***
package mcas_pkg;
   typedef struct packed
   {
      logic [3:0] chan;
      logic [11:0] data;
   } mcas_word_t;

   typedef enum logic [1:0]
   {
      MCAS_IDLE = 2'b00,
      MCAS_CONV = 2'b01,
      MCAS_PUSH = 2'b10
   } mcas_state_t;
endpackage : mcas_pkg

// *** core/mcas_scan_top.sv ***
`timescale 1ns/100ps
`include "mcas_defines.svh"

// ----------------------------------------
// Word buffer between sequencer and controller
// ----------------------------------------
module mcas_fifo
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16,
   parameter int AW = $clog2(DEPTH)
)
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q, wr_d, rd_q, rd_d;
   logic push, pop;

   assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
   assign out_valid = (wr_q != rd_q);
   assign out_data = mem_q[rd_q[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      wr_d = push ? wr_q + 1'h1 : wr_q;
      rd_d = pop ? rd_q + 1'h1 : rd_q;
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end

   always_ff @(posedge clock)
   begin
      if (push)
      begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end
endmodule : mcas_fifo

// ----------------------------------------
// Channel scan sequencer and input word
// ----------------------------------------
module mcas_scan_top
#(
   parameter logic [`MCAS_TMR_W-1:0] CONV_CYCLES = `MCAS_TMR_W'(`MCAS_CONV_CYCLES)
)
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [3:0] chan_jumpers,
   input wire logic range_lo_bank,
   input wire logic range_hi_bank,
   output logic adc_start,
   output logic [3:0] adc_chan,
   output logic adc_range,
   input wire logic [11:0] adc_data,
   input wire logic word_read,
   output logic word_ready,
   output logic [15:0] in_word
);
   mcas_pkg::mcas_state_t state_q, state_d;
   logic [3:0] jmp_m_q, jmp_q;
   logic [1:0] rng_m_q, rng_q;
   logic [3:0] chan_q, chan_d;
   logic [`MCAS_TMR_W-1:0] tmr_q, tmr_d;
   logic [11:0] sample_q, sample_d;
   logic start_q, start_d, range_q, range_d;
   logic [1:0] settle_q, settle_d;
   mcas_pkg::mcas_word_t word_q, word_d, push_word, pop_word;
   logic push_valid, push_ready, pop_valid, pop_ready, accept;

   // ----------------------------------------
   // Jumper and range synchronisers
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         jmp_m_q <= `MCAS_JMP_RESET; // RULE8
         jmp_q <= `MCAS_JMP_RESET; // RULE8
         rng_m_q <= {2{`MCAS_RANGE_RESET}}; // RULE8
         rng_q <= {2{`MCAS_RANGE_RESET}}; // RULE8
      end
      else
      begin
         jmp_m_q <= chan_jumpers;
         jmp_q <= jmp_m_q;
         rng_m_q <= {range_hi_bank, range_lo_bank};
         rng_q <= rng_m_q;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // Last enabled index equals jumper sum: count is sum plus one
   assign push_word = '{chan: chan_q, data: sample_q}; // RULE12 RULE13
   assign push_valid = (state_q == mcas_pkg::MCAS_PUSH) && (chan_q <= jmp_q); // RULE3
   assign accept = (state_q == mcas_pkg::MCAS_PUSH) && (push_ready || chan_q > jmp_q);

   always_comb
   begin
      state_d = state_q;
      chan_d = chan_q;
      tmr_d = tmr_q;
      sample_d = sample_q;
      start_d = 1'h0;
      range_d = range_q;
      settle_d = (settle_q == `MCAS_SYNC_CYCLES) ? settle_q : settle_q + 2'h1;
      unique case (state_q)
         mcas_pkg::MCAS_IDLE:
         begin
            if (chan_q > jmp_q)
            begin
               chan_d = `MCAS_CHAN_FIRST; // RULE3
            end
            // No start until the synchronisers carry the real range pins
            else if (settle_q == `MCAS_SYNC_CYCLES) // RULE6
            begin
               start_d = 1'h1;
               range_d = rng_q[chan_q[`MCAS_BANK_BIT]]; // RULE6 RULE7
               tmr_d = CONV_CYCLES - 1'h1; // RULE4
               state_d = mcas_pkg::MCAS_CONV;
            end
         end
         mcas_pkg::MCAS_CONV:
         begin
            if (tmr_q == '0)
            begin
               sample_d = adc_data; // RULE5
               state_d = mcas_pkg::MCAS_PUSH;
            end
            else
            begin
               tmr_d = tmr_q - 1'h1; // RULE4
            end
         end
         mcas_pkg::MCAS_PUSH:
         begin
            if (accept)
            begin
               chan_d = (chan_q >= jmp_q) ? `MCAS_CHAN_FIRST : chan_q + 1'h1; // RULE2 RULE11
               state_d = mcas_pkg::MCAS_IDLE;
            end
         end
         default:
         begin
            state_d = mcas_pkg::MCAS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q <= mcas_pkg::MCAS_IDLE;
         chan_q <= `MCAS_CHAN_FIRST;
         tmr_q <= '0;
         sample_q <= '0;
         start_q <= 1'h0;
         range_q <= `MCAS_RANGE_RESET;
         settle_q <= 2'h0;
      end
      else
      begin
         state_q <= state_d;
         chan_q <= chan_d;
         tmr_q <= tmr_d;
         sample_q <= sample_d;
         start_q <= start_d;
         range_q <= range_d;
         settle_q <= settle_d;
      end
   end

   assign adc_start = start_q;
   assign adc_chan = chan_q;
   assign adc_range = range_q;

   mcas_fifo
   #(
      .WIDTH(`MCAS_WORD_W),
      .DEPTH(`MCAS_FIFO_DEPTH)
   )
   u_fifo
   (
      .clock(clock),
      .rst_b(rst_b),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_word),
      .out_valid(pop_valid),
      .out_ready(pop_ready),
      .out_data(pop_word)
   );

   // ----------------------------------------
   // Controller input word
   // ----------------------------------------
   assign pop_ready = word_read; // RULE9
   assign word_ready = pop_valid;

   always_comb
   begin
      word_d = (word_read && pop_valid) ? pop_word : word_q; // RULE10
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         word_q <= '0;
      end
      else
      begin
         word_q <= word_d;
      end
   end

   assign in_word = word_q; // RULE1

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_begin;
      start_q && state_q == mcas_pkg::MCAS_CONV;
   endsequence

   sequence s_running;
      state_q == mcas_pkg::MCAS_CONV && !start_q;
   endsequence

   a_conv_slot: assert property (@(posedge clock) disable iff (!rst_b) // RULE4
      (state_q == mcas_pkg::MCAS_CONV && state_d != mcas_pkg::MCAS_CONV) |-> tmr_q == '0)
      else $error("conversion slot ended early");

   a_start_pulse: assert property (@(posedge clock) disable iff (!rst_b) // RULE4
      start_q |-> s_begin ##1 s_running)
      else $error("start not a single pulse into conversion");

   a_chan_advance: assert property (@(posedge clock) disable iff (!rst_b) // RULE10
      (accept && chan_q < jmp_q) |=> chan_q == $past(chan_q) + 4'h1)
      else $error("channel did not advance by one");

   a_chan_wrap: assert property (@(posedge clock) disable iff (!rst_b) // RULE11
      (accept && chan_q >= jmp_q) |=> chan_q == `MCAS_CHAN_FIRST)
      else $error("channel did not wrap");

   a_push_range: assert property (@(posedge clock) disable iff (!rst_b) // RULE3
      (push_valid && push_ready) |-> push_word.chan <= jmp_q)
      else $error("disabled channel reported");

   a_bank_range: assert property (@(posedge clock) disable iff (!rst_b) // RULE6
      start_q |-> adc_range == $past(rng_q[chan_q[`MCAS_BANK_BIT]]))
      else $error("wrong bank range select");

   a_sample_take: assert property (@(posedge clock) disable iff (!rst_b) // RULE13
      (state_q == mcas_pkg::MCAS_CONV && tmr_q == '0) |=> sample_q == $past(adc_data))
      else $error("sample not captured");

   a_word_load: assert property (@(posedge clock) disable iff (!rst_b) // RULE9
      (word_read && pop_valid) |=> in_word == $past(pop_word))
      else $error("input word not loaded");

   a_word_hold: assert property (@(posedge clock) disable iff (!rst_b) // RULE10
      !(word_read && pop_valid) |=> $stable(in_word))
      else $error("input word changed without read");
endmodule : mcas_scan_top

// *** test/mcas_conv_model.sv ***
`timescale 1ns/100ps

// ----------------------------------------
// Converter seen from the sequencer
// ----------------------------------------
module mcas_conv_model
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic adc_start,
   input wire logic [3:0] adc_chan,
   input wire logic adc_range,
   output logic [11:0] adc_data,
   output logic [17:0] start_gap
);
   logic [17:0] cnt_q;

   // Result tags channel and range so the bench can trace each word
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         adc_data <= 12'hA5A;
         start_gap <= 18'h0;
         cnt_q <= 18'h0;
      end
      else if (adc_start)
      begin
         adc_data <= {adc_chan, 3'h5, adc_range, adc_chan};
         start_gap <= cnt_q;
         cnt_q <= 18'h1;
      end
      else
      begin
         cnt_q <= cnt_q + 18'h1;
      end
   end
endmodule : mcas_conv_model

// *** test/mcas_scan_top_bench.sv ***
`timescale 1ns/100ps

module mcas_scan_top_bench;
   localparam int CONV = 20;
   logic clock = 1'h0;
   logic rst_b = 1'h0;
   logic [3:0] chan_jumpers = 4'hF;
   logic range_lo_bank = 1'h0;
   logic range_hi_bank = 1'h0;
   logic word_read = 1'h0;
   logic adc_start, adc_range, word_ready;
   logic [3:0] adc_chan;
   logic [11:0] adc_data;
   logic [15:0] in_word;
   logic [17:0] start_gap;
   logic [3:0] exp_ch;
   int num_errors = 0;
   int n_compared = 0;

   always #4 clock = ~clock;

   mcas_scan_top #(.CONV_CYCLES(18'(CONV))) mcas_scan_top_i (.clock(clock), .rst_b(rst_b),
      .chan_jumpers(chan_jumpers), .range_lo_bank(range_lo_bank),
      .range_hi_bank(range_hi_bank), .adc_start(adc_start), .adc_chan(adc_chan),
      .adc_range(adc_range), .adc_data(adc_data), .word_read(word_read),
      .word_ready(word_ready), .in_word(in_word));

   mcas_conv_model mcas_conv_model_i (.clock(clock), .rst_b(rst_b), .adc_start(adc_start),
      .adc_chan(adc_chan), .adc_range(adc_range), .adc_data(adc_data),
      .start_gap(start_gap));

   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   function automatic logic [15:0] exp_word(input logic [3:0] ch);
      logic rng;
      rng = ch[3] ? range_hi_bank : range_lo_bank;
      return {ch, ch, 3'h5, rng, ch};
   endfunction : exp_word

   task automatic do_reset(input logic [3:0] jmp, input logic lo, input logic hi);
      @(negedge clock);
      rst_b = 1'h0;
      chan_jumpers = jmp;
      range_lo_bank = lo;
      range_hi_bank = hi;
      repeat (20) @(negedge clock);
      check("reset word", {2'h0, in_word}, 18'h0);
      rst_b = 1'h1;
      exp_ch = 4'h0;
   endtask : do_reset

   // Burst keeps the read strobe high so words are taken every cycle
   task automatic read_words(input int n, input logic [3:0] last, input logic burst);
      int w;
      for (int i = 0; i < n; i++)
      begin
         w = 0;
         if (burst)
            check("burst ready", {17'h0, word_ready}, 18'h1);
         while (word_ready !== 1'h1 && w < 1000)
         begin
            @(negedge clock);
            w++;
         end
         check("ready wait", {17'h0, word_ready}, 18'h1);
         word_read = 1'h1;
         @(negedge clock);
         check("in_word", {2'h0, in_word}, {2'h0, exp_word(exp_ch)});
         exp_ch = (exp_ch == last) ? 4'h0 : exp_ch + 4'h1;
         if (!burst)
         begin
            word_read = 1'h0;
            @(negedge clock);
         end
      end
      word_read = 1'h0;
   endtask : read_words

   task automatic finish_test();
      if (num_errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   initial
   begin
      repeat (20000) @(posedge clock);
      num_errors++;
      finish_test();
   end

   initial
   begin
      do_reset(4'hF, 1'h0, 1'h0);
      @(negedge clock);
      word_read = 1'h1;
      @(negedge clock);
      word_read = 1'h0;
      check("empty read", {2'h0, in_word}, 18'h0);
      read_words(17, 4'hF, 1'h0);
      check("slot gap", start_gap, 18'(CONV + 2));
      repeat (18 * (CONV + 2)) @(negedge clock);
      read_words(16, 4'hF, 1'h1);
      do_reset(4'h1, 1'h1, 1'h0);
      read_words(5, 4'h1, 1'h0);
      do_reset(4'h9, 1'h0, 1'h1);
      read_words(11, 4'h9, 1'h0);
      do_reset(4'h0, 1'h1, 1'h1);
      read_words(3, 4'h0, 1'h0);
      finish_test();
   end
endmodule : mcas_scan_top_bench
